// ---- lfm_fault_monitor.v ----
/*
 * Fault supervision and dimming gates for a three-channel LED driver.
 * Assumes analog comparators arrive as synchronous levels and that the
 * fault lines are resolved outside from the output enables.
 */
// Overview of operation
// - A short, single-short or open fault is reported only after 2 ms, or 7 dim cycles when pulsing.
// - Each channel has its own dimming input gating its current source.
// - A dimming input held low keeps its channel off.
// - Four fault sources are watched: single-LED short, output short, open load, over-temperature.
// - Single shorts go to the single-short line, the rest to the general line.
// - Both fault lines are open drain with a weak pull-up only.
// - A low shared general line, from any device, shuts all outputs off except a channel with a live open load, unless over-temperature or a latched output short.
// - The general line is released by an external high, an enable toggle or power cycle.
// - Without a controller a latched fault stays until power cycles.
// - Thermal foldback is off while its threshold pin is grounded.
// - Thermal and open faults self-release; others hold until cleared.
// - On open load the open channel stays on, others off, unless the line is held high; over-temperature or a latched output short turns all off.
`timescale 1ns/1ns
`default_nettype none
`include "lfm_defines.vh"

module lfm_fault_monitor #(
    parameter [`LFM_CNT_W-1:0] DEGLITCH_CYC = `LFM_DEGLITCH_CYC
) (
    input  wire       i_clock,              // 250 MHz core clock
    input  wire       i_rst_n,              // Power-on reset, active low
    input  wire       i_enable,             // Device enable pin
    input  wire [2:0] i_channel_dim_input,  // Per-channel dimming
    input  wire       i_pwm_mode,           // Dimming is pulsing
    input  wire [2:0] i_single_short,       // String sense below ref
    input  wire [2:0] i_output_short,       // Output below short level
    input  wire [2:0] i_open_load,          // Headroom below open level
    input  wire       i_over_temp,          // Thermal shutdown level
    input  wire       i_foldback_pin_gnd,   // Foldback pin tied low
    input  wire       i_fault_in,           // General line level
    input  wire       i_fault_s_in,         // Single-short line level
    output reg  [2:0] o_channel_current_output, // Channel source on
    output reg        o_fault_oe,           // Pull general line low
    output reg        o_fault_out,          // Always 0 when driving
    output reg        o_fault_s_oe,         // Pull single line low
    output reg        o_fault_s_out,        // Always 0 when driving
    output reg        o_foldback_en         // Thermal foldback active
);
    wire [2:0] q_ss;
    wire [2:0] q_sh;
    wire [2:0] q_ol;
    reg        en_q;
    reg        ss_latch;
    reg        sh_latch;
    reg        fault_drv_q;
    reg  [2:0] next_out;

    genvar g;
    generate
        for (g = 0; g < `LFM_NCH; g = g + 1) begin : g_ch
            lfm_deglitch #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_ss (
                .i_clock    (i_clock),
                .i_rst_n    (i_rst_n),
                .i_cond     (i_single_short[g]),
                .i_dim      (i_channel_dim_input[g]),
                .i_pwm_mode (i_pwm_mode),
                .o_qual     (q_ss[g])
            );
            lfm_deglitch #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_sh (
                .i_clock    (i_clock),
                .i_rst_n    (i_rst_n),
                .i_cond     (i_output_short[g]),
                .i_dim      (i_channel_dim_input[g]),
                .i_pwm_mode (i_pwm_mode),
                .o_qual     (q_sh[g])
            );
            lfm_deglitch #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_ol (
                .i_clock    (i_clock),
                .i_rst_n    (i_rst_n),
                .i_cond     (i_open_load[g]),
                .i_dim      (i_channel_dim_input[g]),
                .i_pwm_mode (i_pwm_mode),
                .o_qual     (q_ol[g])
            );
        end
    endgenerate

    // Any of the three channel flags set
    function lfm_any;
        input [2:0] flags;
        begin
            lfm_any = |flags;
        end
    endfunction

    // Keep only the masked channels, or drop them
    function [2:0] lfm_sel;
        input [2:0] base;
        input [2:0] mask;
        input       keep;
        begin
            lfm_sel = keep ? (base & mask) : (base & ~mask);
        end
    endfunction

    // Channel gating modes, one-hot
    localparam [3:0] GATE_ALL_OFF = 4'h1;
    localparam [3:0] GATE_HELD    = 4'h2;
    localparam [3:0] GATE_OPEN    = 4'h4;
    localparam [3:0] GATE_NORMAL  = 4'h8;

    reg  [3:0] gate_mode;

    // Line seen high while this device pulls it: someone overrides
    wire       fault_overridden = fault_drv_q & i_fault_in;
    wire       en_toggle        = i_enable ^ en_q;
    wire       ss_any           = lfm_any(q_ss);
    wire       sh_any           = lfm_any(q_sh);
    wire       open_any         = lfm_any(q_ol);
    // Gate on the live condition too, so a cleared open ends open-load gating at once
    wire [2:0] open_now         = q_ol & i_open_load;
    wire       open_gate        = lfm_any(open_now);
    wire       gen_fault        = sh_latch | open_any | i_over_temp;
    wire       fault_pull       = gen_fault & ~fault_overridden;
    wire [2:0] dim_on           = i_channel_dim_input & {3{i_enable}};

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q        <= 1'b0;
            ss_latch    <= 1'b0;
            sh_latch    <= 1'b0;
            fault_drv_q <= 1'b0;
        end else begin
            en_q <= i_enable;
            // Latches clear by enable toggle or power cycle, the output-short latch also by an override;
            // a new qualification wins over a clear in the same cycle
            if (ss_any)
                ss_latch <= 1'b1;
            else if (en_toggle)
                ss_latch <= 1'b0;
            if (sh_any)
                sh_latch <= 1'b1;
            else if (en_toggle || fault_overridden)
                sh_latch <= 1'b0;
            fault_drv_q <= gen_fault;
        end
    end

    // Priority: heat, held-high line, latched short, open load, low bus.
    // Open load comes before the bus check because this device pulls
    // the bus low itself and must still keep the open string lit.
    always @* begin
        if (i_over_temp)
            gate_mode = GATE_ALL_OFF;
        else if (fault_overridden)
            gate_mode = GATE_HELD;
        else if (sh_latch)
            gate_mode = GATE_ALL_OFF;
        else if (open_gate)
            gate_mode = GATE_OPEN;
        else if (!i_fault_in)
            gate_mode = GATE_ALL_OFF;
        else
            gate_mode = GATE_NORMAL;
    end

    // Held high: shorted strings off, open strings stay on
    always @* begin
        case (gate_mode)
            GATE_ALL_OFF: next_out = 3'h0;
            GATE_HELD:    next_out = lfm_sel(dim_on, q_sh, 1'b0);
            GATE_OPEN:    next_out = lfm_sel(dim_on, open_now, 1'b1);
            GATE_NORMAL:  next_out = dim_on;
            default:      next_out = 3'h0;
        endcase
    end

    // Channel sources
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_channel_current_output <= 3'h0;
        end else begin
            o_channel_current_output <= next_out;
        end
    end

    // General line: only ever pulled low, never driven high
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fault_oe  <= 1'b0;
            o_fault_out <= 1'b0;
        end else begin
            o_fault_oe  <= fault_pull;
            o_fault_out <= 1'b0;
        end
    end

    // Single-short line: only ever pulled low, never driven high
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fault_s_oe  <= 1'b0;
            o_fault_s_out <= 1'b0;
        end else begin
            o_fault_s_oe  <= ss_latch;
            o_fault_s_out <= 1'b0;
        end
    end

    // Foldback enable follows its pin one cycle late
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_foldback_en <= 1'b0;
        end else begin
            o_foldback_en <= ~i_foldback_pin_gnd;
        end
    end
endmodule // lfm_fault_monitor
`default_nettype wire

// ---- lfm_defines.vh ----
/*
 * Constants for the LED driver fault monitor: deglitch timing, cycle
 * thresholds and counter widths.
 * Assumes a 250 MHz core clock.
 */
`ifndef LFM_DEFINES_VH
`define LFM_DEFINES_VH

`define LFM_CLK_PERIOD_NS   4
`define LFM_DEGLITCH_US     2000
`define LFM_DEGLITCH_CYC    ((`LFM_DEGLITCH_US * 1000) / `LFM_CLK_PERIOD_NS)
`define LFM_PWM_CYC         7
`define LFM_CNT_W           20
`define LFM_PWM_CNT_W       3
`define LFM_NCH             3

`endif

// ---- lfm_deglitch.v ----
/*
 * One qualification timer: a condition must persist for a deglitch
 * time (steady mode) or a count of consecutive dimming cycles.
 * Assumes inputs synchronous to i_clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lfm_defines.vh"

module lfm_deglitch #(
    parameter [`LFM_CNT_W-1:0] DEGLITCH_CYC = `LFM_DEGLITCH_CYC
) (
    input  wire i_clock,     // Core clock
    input  wire i_rst_n,     // Async reset, active low
    input  wire i_cond,      // Raw fault condition
    input  wire i_dim,       // Channel dimming input
    input  wire i_pwm_mode,  // Dimming is pulsing
    output reg  o_qual       // Qualified fault level
);
    reg [`LFM_CNT_W-1:0]     time_cnt;
    reg [`LFM_PWM_CNT_W-1:0] cyc_cnt;
    reg                      dim_q;
    reg                      seen_in_cycle;
    wire                     dim_rise = i_dim & ~dim_q;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            time_cnt      <= {`LFM_CNT_W{1'b0}};
            cyc_cnt       <= {`LFM_PWM_CNT_W{1'b0}};
            dim_q         <= 1'b0;
            seen_in_cycle <= 1'b0;
            o_qual        <= 1'b0;
        end else begin
            dim_q <= i_dim;
            if (!i_pwm_mode) begin
                cyc_cnt <= {`LFM_PWM_CNT_W{1'b0}};
                if (!i_cond) begin
                    time_cnt <= {`LFM_CNT_W{1'b0}};
                    o_qual   <= 1'b0;
                end else if (time_cnt >= DEGLITCH_CYC - 1'b1) begin
                    o_qual <= 1'b1;
                end else begin
                    time_cnt <= time_cnt + 1'b1;
                end
            end else begin
                time_cnt <= {`LFM_CNT_W{1'b0}};
                // Condition only meaningful while the channel is on
                if (i_dim && i_cond)
                    seen_in_cycle <= 1'b1;
                if (dim_rise) begin
                    // Rise edge sample opens the new cycle, so it must count
                    seen_in_cycle <= i_cond;
                    if (!seen_in_cycle) begin
                        cyc_cnt <= {`LFM_PWM_CNT_W{1'b0}};
                        o_qual  <= 1'b0;
                    end else if (cyc_cnt >= `LFM_PWM_CYC - 1) begin
                        o_qual <= 1'b1;
                    end else begin
                        cyc_cnt <= cyc_cnt + 1'b1;
                    end
                end
            end
        end
    end
endmodule // lfm_deglitch
`default_nettype wire

// ---- lfm_props.sv ----
/* Port checker for lfm_fault_monitor.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module lfm_props (
    input wire logic       i_clock,                  // Clock
    input wire logic       i_rst_n,                  // Reset
    input wire logic       i_enable,                 // Enable
    input wire logic [2:0] i_channel_dim_input,      // Dimming
    input wire logic       i_pwm_mode,               // Pulsing
    input wire logic [2:0] i_single_short,           // Single short
    input wire logic [2:0] i_open_load,              // Open load
    input wire logic       i_foldback_pin_gnd,       // Foldback off
    input wire logic       i_fault_in,               // General line
    input wire logic [2:0] o_channel_current_output, // Channels
    input wire logic       o_fault_oe,               // General drive
    input wire logic       o_fault_out,              // Drive level
    input wire logic       o_fault_s_oe,             // Single drive
    input wire logic       o_fault_s_out,            // Drive level
    input wire logic       o_foldback_en             // Foldback
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [1:0] en_age;
    // Enable toggle clear needs a few cycles to land
    always_ff @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n) en_age <= 2'h0;
        else if ($changed(i_enable)) en_age <= 2'h0;
        else if (en_age != 2'h3) en_age <= en_age + 2'h1;
    sequence s_fold_low; i_foldback_pin_gnd [*2]; endsequence
    sequence s_fresh;
        $rose(|i_single_short) && !i_pwm_mode && !o_fault_s_oe;
    endsequence
    property p_fold; s_fold_low |-> !o_foldback_en; endproperty
    property p_dim;
        !i_channel_dim_input[0] |=> !o_channel_current_output[0];
    endproperty
    property p_drain; !o_fault_out && !o_fault_s_out; endproperty
    property p_deglitch; s_fresh |-> !o_fault_s_oe [*8]; endproperty
    property p_cause; $rose(o_fault_s_oe) |-> $past(|i_single_short, 3);
    endproperty
    property p_bus; !i_fault_in && !(|i_open_load) |=>
        o_channel_current_output == 3'h0; endproperty
    property p_override; o_fault_oe && i_fault_in |-> ##[1:2] !o_fault_oe;
    endproperty
    property p_hold; o_fault_s_oe && en_age == 2'h3 |=> o_fault_s_oe;
    endproperty
    a_fold: assert property (p_fold) else $error("foldback on");
    a_dim: assert property (p_dim) else $error("dim gate");
    a_drain: assert property (p_drain) else $error("drove high");
    a_deglitch: assert property (p_deglitch) else $error("early");
    a_cause: assert property (p_cause) else $error("no cause");
    a_bus: assert property (p_bus) else $error("bus low");
    a_override: assert property (p_override) else $error("held");
    a_hold: assert property (p_hold) else $error("latch lost");
endmodule // lfm_props
bind lfm_fault_monitor lfm_props u_props (.*);
`default_nettype wire

// ---- lfm_line_partner.sv ----
/* Shared fault lines: weak pull-up, other devices on the general line only, external pull-high.
   Assumes enables come from the monitor under test. */
`timescale 1ns/1ns
`default_nettype none
module lfm_line_partner (
    input  wire logic i_oe,       // Monitor pulls general line
    input  wire logic i_s_oe,     // Monitor pulls single line
    input  wire logic i_ext_high, // Strong external pull-high
    input  wire logic i_ext_low,  // Another device faulted
    output var  logic o_line,     // General line level
    output var  logic o_s_line    // Single-short line level
);
    // Released lines float up; strong pull-high beats pull-downs
    assign o_line   = i_ext_high | ~(i_oe | i_ext_low);
    assign o_s_line = i_ext_high | ~i_s_oe;
endmodule // lfm_line_partner
`default_nettype wire

// ---- lfm_fault_monitor_tb_top.sv ----
/* Self-checking bench for lfm_fault_monitor.
   Assumes a 20-cycle deglitch parameter and the line partner. */
`timescale 1ns/1ns
`default_nettype none
module lfm_fault_monitor_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, pwm = 1'b0, hot = 1'b0;
    logic gnd = 1'b0, xhi = 1'b0, xlo = 1'b0, go = 1'b0;
    logic [2:0] dim = 3'h7, ss = 3'h0, os = 3'h0, ol = 3'h0, chan;
    logic line, s_line, oe, s_oe, fold;
    logic [31:0] lfsr = 32'hBBCAA44E;
    logic [11:0] q[$];
    logic [11:0] e;
    int fail_count = 0, checks_done = 0, i;
    always #2 clk = ~clk;
    lfm_fault_monitor #(.DEGLITCH_CYC(20'h00014)) dut (.i_clock(clk),
        .i_rst_n(rst_n), .i_enable(en), .i_channel_dim_input(dim),
        .i_pwm_mode(pwm), .i_single_short(ss), .i_output_short(os),
        .i_open_load(ol), .i_over_temp(hot), .i_foldback_pin_gnd(gnd),
        .i_fault_in(line), .i_fault_s_in(s_line), .o_fault_out(),
        .o_channel_current_output(chan), .o_fault_oe(oe),
        .o_fault_s_oe(s_oe), .o_fault_s_out(), .o_foldback_en(fold));
    lfm_line_partner u_line (.i_oe(oe), .i_s_oe(s_oe), .i_ext_high(xhi),
        .i_ext_low(xlo), .o_line(line), .o_s_line(s_line));
    function automatic [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            dim = 3'h0;
            cyc(2);
            dim = 3'h7;
            cyc(2);
        end
    endtask
    // Mask then value of {channels, general drive, single drive, foldback}
    task automatic want(input [5:0] m, input [5:0] v);
        q.push_back({m, v});
        go = ~go;
    endtask
    task automatic chk(input [5:0] s, input [5:0] x);
        checks_done++;
        if (s !== x) begin
            fail_count++;
            $display("Error %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(go) begin
        e = q.pop_front();
        chk({chan, oe, s_oe, fold} & e[11:6], e[5:0]);
    end
    initial begin
        #20000;
        fail_count++;
        print_verdict;
    end
    initial begin
        cyc(20);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            dim = lfsr[2:0];
            gnd = lfsr[3];
            cyc(2);
            want(6'h3D, {dim, 2'h0, ~gnd});
        end
        $display("dimming test done");
        dim = 3'h7;
        ss = 3'h2;
        cyc(10);
        ss = 3'h0;
        cyc(1);
        ss = 3'h2;
        cyc(15);
        want(6'h02, 6'h00);
        cyc(10);
        want(6'h3E, 6'h3A);
        ss = 3'h0;
        cyc(5);
        want(6'h02, 6'h02);
        en = 1'b0;
        cyc(1);
        en = 1'b1;
        cyc(4);
        want(6'h02, 6'h00);
        $display("single short test done");
        os = 3'h4;
        cyc(25);
        want(6'h3C, 6'h04);
        os = 3'h0;
        cyc(5);
        want(6'h04, 6'h04);
        xhi = 1'b1;
        cyc(4);
        want(6'h04, 6'h00);
        xhi = 1'b0;
        ol = 3'h1;
        cyc(25);
        want(6'h3C, 6'h0C);
        ol = 3'h0;
        hot = 1'b1;
        cyc(25);
        want(6'h3C, 6'h04);
        hot = 1'b0;
        cyc(4);
        want(6'h3C, 6'h38);
        xlo = 1'b1;
        cyc(2);
        want(6'h38, 6'h00);
        xlo = 1'b0;
        $display("general line test done");
        pwm = 1'b1;
        ol = 3'h2;
        pulse(6);
        want(6'h04, 6'h00);
        pulse(4);
        want(6'h04, 6'h04);
        $display("pulsed test done");
        pwm = 1'b0;
        ol = 3'h0;
        ss = 3'h1;
        cyc(25);
        want(6'h02, 6'h02);
        ss = 3'h0;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        want(6'h06, 6'h00);
        $display("power cycle test done");
        print_verdict;
    end
endmodule // lfm_fault_monitor_tb_top
`default_nettype wire
